// file: verilog/opm_output_mux.sv
// Behaviour
// - after reset every pin carries its default peripheral signal.
// - one specific bit per option routes only that function to the pin.
// - register 0 bit 8 gpio A0, bit 9 serial3 cs3.
// - register 1 bytes 0-3: gpio A1-A4 or serial3 cs2,cs1, serial2 cs3,cs2.
// - register 2: A5/ext clock; A6/serial2 cs1/timer 31; A7/timer 29.
// - register 3: buffered cs2/timer20/timer19; serial3 clock/enc A; serial3 enable/enc B.
// - register 4: serial3 cs0/enc index; buffered cs3/timer26; converter event/timer28.
// - register 5 byte 1: buffered enable, timer 23, timer 30.
// - register 6 byte 1: buffered cs1, encoder strobe, timer 17.
// - gpio A7 default bit reads set after reset.
// - pin inputs reach every sharing peripheral unselected.
// - mux switches only output drive.
// - writes accepted only when privileged.
// - unprivileged write answers error and leaves register unchanged.
// - all-zero register gives defaults on its pins.
// - each of the 16 pin bytes controls exactly one pin independently; other bytes control none.
// - more than one bit set selects the default.
`timescale 1ns/1ps
`default_nettype none
module opm_output_mux (
   input wire logic mclk,
   input wire logic rst_n,
   input wire opm_pkg::opm_bus_req_type busReq,
   output opm_pkg::opm_bus_rsp_type busRsp,
   input wire opm_pkg::opm_periph_out_type periphOut,
   output logic [opm_pkg::NUM_PINS-1:0] pinOut,
   input wire logic [opm_pkg::NUM_PINS-1:0] pinIn,
   output logic [opm_pkg::NUM_PINS-1:0] pinInToPeriph
);
   import opm_pkg::*;

   // ----------------------------------------
   // pin to register byte map
   // ----------------------------------------
   function automatic logic [7:0] pinByte(input logic [NUM_REGS-1:0][31:0] regs, input int pin);
      logic [7:0] b;
      b = 8'h00;
      case (pin)
         PIN_GPIO_A0: b = regs[0][15:8];
         PIN_GPIO_A1: b = regs[1][7:0];
         PIN_GPIO_A2: b = regs[1][15:8];
         PIN_GPIO_A3: b = regs[1][23:16];
         PIN_GPIO_A4: b = regs[1][31:24];
         PIN_GPIO_A5: b = regs[2][7:0];
         PIN_GPIO_A6: b = regs[2][15:8];
         PIN_GPIO_A7: b = regs[2][23:16];
         PIN_BUF_CS1: b = regs[6][15:8];
         PIN_BUF_CS2: b = regs[3][7:0];
         PIN_BUF_CS3: b = regs[4][15:8];
         PIN_BUF_ENA: b = regs[5][15:8];
         PIN_S3_CLK: b = regs[3][23:16];
         PIN_S3_CS0: b = regs[4][7:0];
         PIN_S3_ENA: b = regs[3][31:24];
         PIN_CONV_EVT: b = regs[4][23:16];
         default: b = 8'h00;
      endcase
      return b;
   endfunction : pinByte

   // only a single-bit byte naming an option leaves the default
   function automatic logic muxPin(input logic [7:0] sel, input logic d, input logic o2, input logic o3);
      logic r;
      r = d;
      if (sel == SEL_OPTION2) begin
         r = o2;
      end else if (sel == SEL_OPTION3) begin
         r = o3;
      end
      return r;
   endfunction : muxPin

   opm_state_type st_r;
   opm_state_type st_nxt;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.rsp.ack = 1'b0;
      st_nxt.rsp.err = 1'b0;
      if (busReq.req) begin
         st_nxt.rsp.ack = 1'b1;
         if (busReq.index >= 3'(NUM_REGS)) begin
            st_nxt.rsp.err = 1'b1;
            st_nxt.rsp.rdata = 32'h0000_0000;
         end else if (busReq.write) begin
            if (busReq.privileged) begin
               st_nxt.selReg[busReq.index] = busReq.wdata;
            end else begin
               st_nxt.rsp.err = 1'b1;
            end
            st_nxt.rsp.rdata = 32'h0000_0000;
         end else begin
            st_nxt.rsp.rdata = st_r.selReg[busReq.index];
         end
      end
      // each pin reads its own byte only; output drive alone is switched
      for (int p = 0; p < NUM_PINS; p++) begin
         st_nxt.pinOut[p] = muxPin(pinByte(st_r.selReg, p), periphOut.dflt[p],
                                   periphOut.opt2[p], periphOut.opt3[p]);
      end
      // pin levels are asynchronous; only the second stage is handed on
      st_nxt.pinInMeta = pinIn;
      st_nxt.pinInSync = st_r.pinInMeta;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_r.selReg[0] <= RST_REG0;
         st_r.selReg[1] <= RST_REG1;
         st_r.selReg[2] <= RST_REG2;
         st_r.selReg[3] <= RST_REG3;
         st_r.selReg[4] <= RST_REG4;
         st_r.selReg[5] <= RST_REG5;
         st_r.selReg[6] <= RST_REG6;
         st_r.rsp <= '0;
         st_r.pinOut <= '0;
         st_r.pinInMeta <= '0;
         st_r.pinInSync <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign busRsp = st_r.rsp;
   assign pinOut = st_r.pinOut;
   // inputs reach all peripherals on the pin unselected, two cycles late
   assign pinInToPeriph = st_r.pinInSync;

   // ----------------------------------------
   // checks: register access
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   // the whole image is compared, so a refused write cannot touch a neighbour either
   a_unpriv_write_err: assert property (
      busReq.req && busReq.write && !busReq.privileged && busReq.index < 3'(NUM_REGS)
      |=> busRsp.err && busRsp.ack && st_r.selReg == $past(st_r.selReg))
      else $error("unprivileged write not refused");
   a_priv_write_takes: assert property (
      busReq.req && busReq.write && busReq.privileged && busReq.index < 3'(NUM_REGS)
      |=> !busRsp.err && st_r.selReg[$past(busReq.index)] == $past(busReq.wdata))
      else $error("privileged write lost");
   a_unmapped_err: assert property (
      busReq.req && busReq.index >= 3'(NUM_REGS)
      |=> busRsp.err)
      else $error("unmapped no error");
   a_read_returns: assert property (
      busReq.req && !busReq.write && busReq.index < 3'(NUM_REGS)
      |=> !busRsp.err && busRsp.rdata == $past(st_r.selReg[busReq.index]))
      else $error("read data wrong");
   a_ack_follows_req: assert property (
      $past(rst_n)
      |-> busRsp.ack == $past(busReq.req))
      else $error("acknowledge not one cycle after request");
   a_err_with_ack: assert property (
      busRsp.err
      |-> busRsp.ack)
      else $error("error without acknowledge");

   // ----------------------------------------
   // checks: reset and pin inputs
   // ----------------------------------------
   a_reset_default: assert property (
      $rose(rst_n)
      |-> st_r.selReg[2][16] && st_r.selReg[0] == RST_REG0)
      else $error("reset value wrong");
   a_reset_loads: assert property (
      $rose(rst_n)
      |-> st_r.selReg == {RST_REG6, RST_REG5, RST_REG4, RST_REG3, RST_REG2, RST_REG1, RST_REG0})
      else $error("reset image wrong");
   a_reset_pins_dflt: assert property (
      $rose(rst_n)
      |=> pinOut == $past(periphOut.dflt))
      else $error("pins not default after reset");
   // two cycles of latency keep metastable levels away from the peripherals
   a_input_pass: assert property (
      $past(rst_n) && $past(rst_n, 2)
      |-> pinInToPeriph == $past(pinIn, 2))
      else $error("input not passed");

   // ----------------------------------------
   // checks: option routing, one pin per byte
   // ----------------------------------------
   a_a0_opt2: assert property (
      st_r.selReg[0][15:8] == SEL_OPTION2
      |=> pinOut[PIN_GPIO_A0] == $past(periphOut.opt2[PIN_GPIO_A0]))
      else $error("gpio A0 option 2 not routed");
   a_a1_opt2: assert property (
      st_r.selReg[1][7:0] == SEL_OPTION2
      |=> pinOut[PIN_GPIO_A1] == $past(periphOut.opt2[PIN_GPIO_A1]))
      else $error("gpio A1 option 2 not routed");
   a_a2_opt2: assert property (
      st_r.selReg[1][15:8] == SEL_OPTION2
      |=> pinOut[PIN_GPIO_A2] == $past(periphOut.opt2[PIN_GPIO_A2]))
      else $error("gpio A2 option 2 not routed");
   a_a3_opt2: assert property (
      st_r.selReg[1][23:16] == SEL_OPTION2
      |=> pinOut[PIN_GPIO_A3] == $past(periphOut.opt2[PIN_GPIO_A3]))
      else $error("gpio A3 option 2 not routed");
   a_a4_opt2: assert property (
      st_r.selReg[1][31:24] == SEL_OPTION2
      |=> pinOut[PIN_GPIO_A4] == $past(periphOut.opt2[PIN_GPIO_A4]))
      else $error("gpio A4 option 2 not routed");
   a_a5_opt2: assert property (
      st_r.selReg[2][7:0] == SEL_OPTION2
      |=> pinOut[PIN_GPIO_A5] == $past(periphOut.opt2[PIN_GPIO_A5]))
      else $error("gpio A5 option 2 not routed");
   a_a6_opt2: assert property (
      st_r.selReg[2][15:8] == SEL_OPTION2
      |=> pinOut[PIN_GPIO_A6] == $past(periphOut.opt2[PIN_GPIO_A6]))
      else $error("gpio A6 option 2 not routed");
   a_a6_opt3: assert property (
      st_r.selReg[2][15:8] == SEL_OPTION3
      |=> pinOut[PIN_GPIO_A6] == $past(periphOut.opt3[PIN_GPIO_A6]))
      else $error("gpio A6 option 3 not routed");
   a_a7_opt2: assert property (
      st_r.selReg[2][23:16] == SEL_OPTION2
      |=> pinOut[PIN_GPIO_A7] == $past(periphOut.opt2[PIN_GPIO_A7]))
      else $error("gpio A7 option 2 not routed");
   a_bcs2_opt2: assert property (
      st_r.selReg[3][7:0] == SEL_OPTION2
      |=> pinOut[PIN_BUF_CS2] == $past(periphOut.opt2[PIN_BUF_CS2]))
      else $error("buffered cs2 option 2 not routed");
   a_bcs2_opt3: assert property (
      st_r.selReg[3][7:0] == SEL_OPTION3
      |=> pinOut[PIN_BUF_CS2] == $past(periphOut.opt3[PIN_BUF_CS2]))
      else $error("buffered cs2 option 3 not routed");
   a_s3clk_opt2: assert property (
      st_r.selReg[3][23:16] == SEL_OPTION2
      |=> pinOut[PIN_S3_CLK] == $past(periphOut.opt2[PIN_S3_CLK]))
      else $error("serial3 clock option 2 not routed");
   a_s3ena_opt2: assert property (
      st_r.selReg[3][31:24] == SEL_OPTION2
      |=> pinOut[PIN_S3_ENA] == $past(periphOut.opt2[PIN_S3_ENA]))
      else $error("serial3 enable option 2 not routed");
   a_s3cs0_opt2: assert property (
      st_r.selReg[4][7:0] == SEL_OPTION2
      |=> pinOut[PIN_S3_CS0] == $past(periphOut.opt2[PIN_S3_CS0]))
      else $error("serial3 cs0 option 2 not routed");
   a_bcs3_opt2: assert property (
      st_r.selReg[4][15:8] == SEL_OPTION2
      |=> pinOut[PIN_BUF_CS3] == $past(periphOut.opt2[PIN_BUF_CS3]))
      else $error("buffered cs3 option 2 not routed");
   a_option2_route: assert property (
      st_r.selReg[4][23:16] == SEL_OPTION2
      |=> pinOut[PIN_CONV_EVT] == $past(periphOut.opt2[PIN_CONV_EVT]))
      else $error("option 2 not routed");
   a_bena_opt2: assert property (
      st_r.selReg[5][15:8] == SEL_OPTION2
      |=> pinOut[PIN_BUF_ENA] == $past(periphOut.opt2[PIN_BUF_ENA]))
      else $error("buffered enable option 2 not routed");
   a_bena_opt3: assert property (
      st_r.selReg[5][15:8] == SEL_OPTION3
      |=> pinOut[PIN_BUF_ENA] == $past(periphOut.opt3[PIN_BUF_ENA]))
      else $error("buffered enable option 3 not routed");
   a_bcs1_opt2: assert property (
      st_r.selReg[6][15:8] == SEL_OPTION2
      |=> pinOut[PIN_BUF_CS1] == $past(periphOut.opt2[PIN_BUF_CS1]))
      else $error("buffered cs1 option 2 not routed");
   a_option3_route: assert property (
      st_r.selReg[6][15:8] == SEL_OPTION3
      |=> pinOut[PIN_BUF_CS1] == $past(periphOut.opt3[PIN_BUF_CS1]))
      else $error("option 3 not routed");

   // ----------------------------------------
   // checks: fall back to the default
   // ----------------------------------------
   // empty and crowded bytes fall back, so a stray write never leaves a pin undriven
   a_default_on_zero: assert property (
      st_r.selReg[3][23:16] == 8'h00
      |=> pinOut[PIN_S3_CLK] == $past(periphOut.dflt[PIN_S3_CLK]))
      else $error("zero byte not default");
   a_multi_bit_dflt: assert property (
      st_r.selReg[5][15:8] == 8'h06
      |=> pinOut[PIN_BUF_ENA] == $past(periphOut.dflt[PIN_BUF_ENA]))
      else $error("multi bit not default");
   a_zero_reg_dflt: assert property (
      st_r.selReg[3] == 32'h0000_0000
      |=> {pinOut[PIN_BUF_CS2], pinOut[PIN_S3_CLK], pinOut[PIN_S3_ENA]}
          == $past({periphOut.dflt[PIN_BUF_CS2], periphOut.dflt[PIN_S3_CLK], periphOut.dflt[PIN_S3_ENA]}))
      else $error("zero register not default");
   a_default_bit: assert property (
      st_r.selReg[2][23:16] == SEL_DEFAULT
      |=> pinOut[PIN_GPIO_A7] == $past(periphOut.dflt[PIN_GPIO_A7]))
      else $error("default bit not routed");

   // ----------------------------------------
   // cover
   // ----------------------------------------
   c_priv_write: cover property (busReq.req && busReq.write && busReq.privileged);
   c_unpriv_write: cover property (busReq.req && busReq.write && !busReq.privileged);
   c_opt3_sel: cover property (st_r.selReg[5][15:8] == SEL_OPTION3);
   c_zero_reg: cover property (st_r.selReg[3] == 32'h0000_0000);
   c_multi_bit: cover property (st_r.selReg[5][15:8] == 8'h06);
endmodule : opm_output_mux
`default_nettype wire

// file: verilog/opm_pkg.sv
package opm_pkg;
   localparam int NUM_REGS = 7;
   localparam int NUM_PINS = 16;
   localparam logic [2:0] REG_ADDR_W = 3'h0;
   // select byte value that picks a pin's default function
   localparam logic [7:0] SEL_DEFAULT = 8'h01;
   localparam logic [7:0] SEL_OPTION2 = 8'h02;
   localparam logic [7:0] SEL_OPTION3 = 8'h04;
   // reset values: only the default bit of each implemented pin byte
   localparam logic [31:0] RST_REG0 = 32'h0000_0100;
   localparam logic [31:0] RST_REG1 = 32'h0101_0101;
   localparam logic [31:0] RST_REG2 = 32'h0001_0101;
   localparam logic [31:0] RST_REG3 = 32'h0101_0001;
   localparam logic [31:0] RST_REG4 = 32'h0001_0101;
   localparam logic [31:0] RST_REG5 = 32'h0000_0100;
   localparam logic [31:0] RST_REG6 = 32'h0000_0100;

   // pin order in the pin vectors
   localparam int PIN_GPIO_A0 = 0;
   localparam int PIN_GPIO_A1 = 1;
   localparam int PIN_GPIO_A2 = 2;
   localparam int PIN_GPIO_A3 = 3;
   localparam int PIN_GPIO_A4 = 4;
   localparam int PIN_GPIO_A5 = 5;
   localparam int PIN_GPIO_A6 = 6;
   localparam int PIN_GPIO_A7 = 7;
   localparam int PIN_BUF_CS1 = 8;
   localparam int PIN_BUF_CS2 = 9;
   localparam int PIN_BUF_CS3 = 10;
   localparam int PIN_BUF_ENA = 11;
   localparam int PIN_S3_CLK = 12;
   localparam int PIN_S3_CS0 = 13;
   localparam int PIN_S3_ENA = 14;
   localparam int PIN_CONV_EVT = 15;

   typedef struct packed {
      logic req;
      logic write;
      logic privileged;
      logic [2:0] index;
      logic [31:0] wdata;
   } opm_bus_req_type;

   typedef struct packed {
      logic ack;
      logic err;
      logic [31:0] rdata;
   } opm_bus_rsp_type;

   // per-pin output candidates: default, option 2, option 3
   typedef struct packed {
      logic [NUM_PINS-1:0] dflt;
      logic [NUM_PINS-1:0] opt2;
      logic [NUM_PINS-1:0] opt3;
   } opm_periph_out_type;

   typedef struct packed {
      logic [NUM_REGS-1:0][31:0] selReg;
      opm_bus_rsp_type rsp;
      logic [NUM_PINS-1:0] pinOut;
      // two-stage synchroniser for the asynchronous pin input levels
      logic [NUM_PINS-1:0] pinInMeta;
      logic [NUM_PINS-1:0] pinInSync;
   } opm_state_type;
endpackage : opm_pkg

// file: test/opm_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module opm_periph_model (
   input wire logic phase,
   output var opm_pkg::opm_periph_out_type periphOut
);
   import opm_pkg::*;
   // option 3 copies another candidate per phase, so a wrong pick cannot pass by luck
   assign periphOut.dflt = phase ? 16'h5A3C : 16'hA5C3;
   assign periphOut.opt2 = ~periphOut.dflt;
   assign periphOut.opt3 = phase ? periphOut.dflt : periphOut.opt2;
endmodule : opm_periph_model
`default_nettype wire

// file: test/output_pin_function_mux_tb.sv
`timescale 1ns/1ps
`default_nettype none
module output_pin_function_mux_tb;
   import opm_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic phase = 1'b0;
   opm_bus_req_type busReq = '0;
   opm_bus_rsp_type busRsp;
   opm_periph_out_type periphOut;
   logic [NUM_PINS-1:0] pinOut;
   logic [NUM_PINS-1:0] pinIn = 16'h0000;
   logic [NUM_PINS-1:0] pinInToPeriph;
   logic [31:0] rstV [NUM_REGS] = '{RST_REG0, RST_REG1, RST_REG2, RST_REG3, RST_REG4, RST_REG5, RST_REG6};
   logic [31:0] shadow [NUM_REGS];
   // select field of each pin, as register*4+byte
   int pinLoc [NUM_PINS] = '{1, 4, 5, 6, 7, 8, 9, 10, 25, 12, 17, 21, 14, 16, 15, 18};
   int errorCnt = 0;
   int numChecks = 0;
   always #2.5 mclk = ~mclk;
   opm_periph_model u_model (.phase(phase), .periphOut(periphOut));
   opm_output_mux u_dut (.mclk(mclk), .rst_n(rst_n), .busReq(busReq), .busRsp(busRsp), .periphOut(periphOut),
      .pinOut(pinOut), .pinIn(pinIn), .pinInToPeriph(pinInToPeriph));
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      numChecks++;
      if (got !== exp) begin
         errorCnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic checkPins();
      logic [7:0] b;
      logic [NUM_PINS-1:0] e;
      logic [NUM_PINS-1:0] prevIn;
      repeat (2) begin
         phase = ~phase;
         // the input path lags the pin by its two synchroniser stages
         prevIn = pinIn;
         pinIn = {pinIn[14:0], ~pinIn[15]};
         @(negedge mclk);
         for (int p = 0; p < NUM_PINS; p++) begin
            b = shadow[pinLoc[p] / 4][pinLoc[p] % 4 * 8 +: 8];
            e[p] = (b == SEL_OPTION2) ? periphOut.opt2[p] : (b == SEL_OPTION3) ? periphOut.opt3[p] : periphOut.dflt[p];
         end
         cmp(32'(pinOut), 32'(e));
         cmp(32'(pinInToPeriph), 32'(prevIn));
      end
   endtask : checkPins
   task automatic acc(input logic wr, input logic priv, input logic [2:0] idx, input logic [31:0] wd,
      input logic eErr);
      @(negedge mclk);
      busReq = '{1'b1, wr, priv, idx, wd};
      @(negedge mclk);
      busReq.req = 1'b0;
      cmp(32'(busRsp.ack), 32'h1);
      cmp(32'(busRsp.err), 32'(eErr));
      cmp(busRsp.rdata, (wr || eErr) ? 32'h0 : shadow[idx]);
      if (wr && priv && !eErr) begin
         shadow[idx] = wd;
      end
      checkPins();
   endtask : acc
   task automatic tReset();
      for (int r = 0; r < NUM_REGS; r++) begin
         acc(1'b0, 1'b1, 3'(r), 32'h0, 1'b0);
      end
      $display("reset test done");
   endtask : tReset
   task automatic tOptions();
      // only implemented bits are written; reserved ones may reach unbonded pads
      for (int r = 0; r < NUM_REGS; r++) begin
         acc(1'b1, 1'b1, 3'(r), rstV[r] << 1, 1'b0);
      end
      acc(1'b1, 1'b1, 3'h2, 32'h0001_0401, 1'b0);
      acc(1'b1, 1'b1, 3'h3, 32'h0101_0004, 1'b0);
      acc(1'b1, 1'b1, 3'h5, 32'h0000_0400, 1'b0);
      acc(1'b1, 1'b1, 3'h6, 32'h0000_0400, 1'b0);
      $display("options test done");
   endtask : tOptions
   task automatic tDefaults();
      acc(1'b1, 1'b1, 3'h3, 32'h0000_0000, 1'b0);
      acc(1'b1, 1'b1, 3'h5, 32'h0000_0600, 1'b0);
      acc(1'b1, 1'b1, 3'h1, 32'h0203_0002, 1'b0);
      $display("defaults test done");
   endtask : tDefaults
   task automatic tAccess();
      acc(1'b1, 1'b0, 3'h2, 32'h0002_0202, 1'b1);
      acc(1'b0, 1'b1, 3'h2, 32'h0, 1'b0);
      acc(1'b1, 1'b1, 3'h7, 32'h0000_0101, 1'b1);
      acc(1'b0, 1'b1, 3'h7, 32'h0, 1'b1);
      $display("access test done");
   endtask : tAccess
   task automatic closeOut();
      $display("checks %0d mismatches %0d", numChecks, errorCnt);
      if (errorCnt == 0 && numChecks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : closeOut
   initial begin
      shadow = rstV;
      repeat (20) @(posedge mclk);
      @(negedge mclk);
      rst_n = 1'b1;
      tReset();
      tOptions();
      tDefaults();
      tAccess();
      closeOut();
   end
   initial begin
      #50us;
      errorCnt++;
      $display("watchdog expired");
      closeOut();
   end
endmodule : output_pin_function_mux_tb
`default_nettype wire
